// *** verilog/flash_cmd_regs.svh ***
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// opcodes
`define OP_WRITE_ENABLE   8'h06
`define OP_VOL_ENABLE     8'h50
`define OP_WRITE_DISABLE  8'h04
`define OP_STATUS1_READ   8'h05
`define OP_STATUS2_READ   8'h35
`define OP_STATUS_WRITE   8'h01
`define OP_STATUS2_WRITE  8'h31
`define OP_READ           8'h03
`define OP_FAST_READ      8'h0B
`define OP_DUAL_READ      8'h3B
`define OP_SET_PARAM      8'hC0

// status byte 1 and 2 field positions
`define S1_BUSY           0
`define S1_LATCH          1
`define S1_WRITE_MASK     8'hFC
`define S2_WRITE_MASK     8'h43
`define S1_RESET          8'h00
`define S2_RESET          8'h00

// read parameter field and dummy counts
`define PARAM_LSB         4
`define PARAM_RESET       2'h0
`define DUMMY_FOUR_0      6'h04
`define DUMMY_FOUR_1      6'h06
`define DUMMY_FOUR_2      6'h08
`define DUMMY_SINGLE      6'h08
`define DUMMY_DUAL        6'h08

// rising edges counted in a frame
`define EDGES_OPCODE      6'h08
`define EDGES_ONE_BYTE    6'h10
`define EDGES_TWO_BYTE    6'h18
`define EDGES_ADDR        6'h20
`define EDGES_MAX         6'h3F

// timing
`define CLK_PERIOD_NS     10
`define WRITE_TIME_NS     5000

`endif

// *** verilog/flash_cmd_pkg.sv ***
`include "flash_cmd_regs.svh"
package flash_cmd_pkg;

    typedef enum logic [1:0] {
        OUT_NONE   = 2'b00,
        OUT_STATUS = 2'b01,
        OUT_SINGLE = 2'b11,
        OUT_DUAL   = 2'b10
    } out_mode_type;

    typedef enum logic {
        WR_IDLE = 1'b0,
        WR_BUSY = 1'b1
    } wr_state_type;

    // first data edge count for an opcode
    function automatic logic [5:0] data_start(input logic [7:0] op,
                                              input logic       four_wire,
                                              input logic [1:0] param);
        logic [5:0] dummy;
        dummy = `DUMMY_SINGLE;
        if (four_wire) begin
            unique case (param)
                2'h0:    dummy = `DUMMY_FOUR_0;
                2'h1:    dummy = `DUMMY_FOUR_1;
                default: dummy = `DUMMY_FOUR_2;
            endcase
        end
        if (op == `OP_FAST_READ) begin
            data_start = `EDGES_ADDR + dummy;
        end else if (op == `OP_DUAL_READ) begin
            data_start = `EDGES_ADDR + `DUMMY_DUAL;
        end else if (op == `OP_READ) begin
            data_start = `EDGES_ADDR;
        end else begin
            data_start = `EDGES_OPCODE;
        end
    endfunction

endpackage

// *** verilog/flash_cmd_seq.sv ***
`timescale 1ns/100ps
`include "flash_cmd_regs.svh"
module flash_cmd_seq #(
    parameter int ADDR_W       = 24,
    parameter int WRITE_CYCLES = (`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // system
    input  wire logic              mclk,
    input  wire logic              nrst,
    // link
    input  wire logic              link_clk,
    input  wire logic              cs_n,
    input  wire logic              io0_in,
    output logic                   io0_out,
    output logic                   io0_oe,
    output logic                   io1_out,
    output logic                   io1_oe,
    // array read port, combinational memory on link_clk
    output logic [ADDR_W-1:0]      array_addr,
    input  wire logic [7:0]        array_data,
    // configuration and status
    input  wire logic              four_wire_command_mode,
    output logic [7:0]             status1_out,
    output logic [7:0]             status2_out,
    output logic [1:0]             read_param_out
);

    localparam int SYNC_W = 19;

    // ---------------- mclk domain ----------------
    logic                          cs_s1_reg;
    logic                          cs_s2_reg;
    logic                          cs_s3_reg;
    logic                          cs_acc_reg;
    logic [7:0]                    status1_reg;
    logic [7:0]                    status2_reg;
    logic [7:0]                    pend1_reg;
    logic [7:0]                    pend2_reg;
    logic                          vol_en_reg;
    logic [1:0]                    read_param_reg;
    flash_cmd_pkg::wr_state_type   wr_state_reg;
    logic [31:0]                   wr_cnt_reg;

    // ---------------- link domain ----------------
    logic                          active_reg;
    logic [5:0]                    cnt_reg;
    logic [23:0]                   shin_reg;
    logic [7:0]                    op_reg;
    logic [7:0]                    byte1_reg;
    logic [7:0]                    byte2_reg;
    logic [2:0]                    pos_reg;
    logic [ADDR_W-1:0]             addr_reg;
    flash_cmd_pkg::out_mode_type   mode_reg;
    logic [SYNC_W-1:0]             ls1_reg;
    logic [SYNC_W-1:0]             ls2_reg;
    logic [SYNC_W-1:0]             ls3_reg;
    logic [SYNC_W-1:0]             lacc_reg;
    logic [7:0]                    shout_reg;

    // chip select: three flops, a change counts when the last two agree
    wire cs_hi   = cs_s2_reg & cs_s3_reg;
    wire cs_lo   = ~cs_s2_reg & ~cs_s3_reg;
    wire cs_rise = cs_hi & ~cs_acc_reg;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cs_s1_reg  <= 1'b1;
            cs_s2_reg  <= 1'b1;
            cs_s3_reg  <= 1'b1;
            cs_acc_reg <= 1'b1;
        end else begin
            cs_s1_reg  <= cs_n;
            cs_s2_reg  <= cs_s1_reg;
            cs_s3_reg  <= cs_s2_reg;
            cs_acc_reg <= cs_hi | (cs_acc_reg & ~cs_lo);
        end
    end

    // link registers are quiet while cs_n is high, so mclk may read them after the rise
    wire busy        = (wr_state_reg == flash_cmd_pkg::WR_BUSY);
    wire latch       = status1_reg[`S1_LATCH];
    wire len_one     = (cnt_reg == `EDGES_ONE_BYTE);
    wire len_two     = (cnt_reg == `EDGES_TWO_BYTE);
    wire op_set_latch = cs_rise & (op_reg == `OP_WRITE_ENABLE);
    wire op_clr_latch = cs_rise & (op_reg == `OP_WRITE_DISABLE);
    wire op_vol      = cs_rise & (op_reg == `OP_VOL_ENABLE);
    wire op_param    = cs_rise & (op_reg == `OP_SET_PARAM) & len_one;
    wire sw1_ok      = (op_reg == `OP_STATUS_WRITE) & (len_one | len_two);
    wire sw2_ok      = (op_reg == `OP_STATUS2_WRITE) & len_one;
    wire sw_req      = cs_rise & (sw1_ok | sw2_ok) & ~busy;
    wire sw_vol      = sw_req & vol_en_reg;
    wire sw_nv       = sw_req & ~vol_en_reg & latch;
    wire wr_done     = busy & (wr_cnt_reg == 32'h0000_0000);

    // masked merge keeps read-only bits untouched
    wire [7:0] new1  = sw1_ok ? ((status1_reg & ~`S1_WRITE_MASK) | (byte1_reg & `S1_WRITE_MASK))
                              : status1_reg;
    wire [7:0] keep2 = status2_reg & ~`S2_WRITE_MASK;
    wire [7:0] new2  = sw2_ok  ? (keep2 | (byte1_reg & `S2_WRITE_MASK))
                     : len_two ? (keep2 | (byte2_reg & `S2_WRITE_MASK))
                     :           keep2;

    // write wins over completion clear; completion and busy start clear the latch
    wire latch_next  = op_set_latch ? 1'b1
                     : (sw_nv | op_clr_latch | wr_done) ? 1'b0
                     : latch;
    wire busy_next   = sw_nv | (busy & ~wr_done);
    wire [7:0] prot1_next = sw_vol ? new1 : wr_done ? pend1_reg : status1_reg;
    wire [7:0] s2_next    = sw_vol ? new2 : wr_done ? pend2_reg : status2_reg;
    wire [7:0] s1_next    = (prot1_next & `S1_WRITE_MASK)
                          | ({7'h00, latch_next} << `S1_LATCH)
                          | ({7'h00, busy_next} << `S1_BUSY);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            status1_reg    <= `S1_RESET;
            status2_reg    <= `S2_RESET;
            pend1_reg      <= `S1_RESET;
            pend2_reg      <= `S2_RESET;
            vol_en_reg     <= 1'b0;
            read_param_reg <= `PARAM_RESET;
            wr_state_reg   <= flash_cmd_pkg::WR_IDLE;
            wr_cnt_reg     <= 32'h0000_0000;
        end else begin
            status1_reg <= s1_next;
            status2_reg <= s2_next;
            if (sw_nv) begin
                pend1_reg <= new1;
                pend2_reg <= new2;
            end
            if (op_vol) begin
                vol_en_reg <= 1'b1;
            end else if (sw_req) begin
                vol_en_reg <= 1'b0;
            end
            if (op_param) begin
                read_param_reg <= byte1_reg[`PARAM_LSB +: 2];
            end
            unique case (wr_state_reg)
                flash_cmd_pkg::WR_IDLE: begin
                    if (sw_nv) begin
                        wr_state_reg <= flash_cmd_pkg::WR_BUSY;
                        wr_cnt_reg   <= 32'(WRITE_CYCLES - 1);
                    end
                end
                flash_cmd_pkg::WR_BUSY: begin
                    if (wr_done) begin
                        wr_state_reg <= flash_cmd_pkg::WR_IDLE;
                    end else begin
                        wr_cnt_reg <= wr_cnt_reg - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    assign status1_out    = status1_reg;
    assign status2_out    = status2_reg;
    assign read_param_out = read_param_reg;

    // ---------------- link side ----------------
    // status reaches the link through three flops per bit; bits change only at the
    // end of a frame or of a write, and eight opcode edges pass before any status bit goes out
    wire [SYNC_W-1:0] sync_src = {four_wire_command_mode, read_param_reg,
                                  status2_reg, status1_reg};
    wire [7:0] l_st1      = lacc_reg[7:0];
    wire [7:0] l_st2      = lacc_reg[15:8];
    wire [1:0] l_param    = lacc_reg[17:16];
    wire       l_four     = lacc_reg[18];
    wire       l_busy     = l_st1[`S1_BUSY];

    wire [5:0] cnt_next   = !active_reg ? 6'h01
                          : (cnt_reg == `EDGES_MAX) ? `EDGES_MAX
                          : cnt_reg + 6'h01;
    wire [7:0] byte_now   = {shin_reg[6:0], io0_in};
    wire [5:0] start      = flash_cmd_pkg::data_start(op_reg, l_four, l_param);
    wire       dual       = (mode_reg == flash_cmd_pkg::OUT_DUAL);
    wire [2:0] pos_next   = (cnt_next <= start) ? 3'h0 : pos_reg + 3'h1;
    wire       boundary_n = dual ? (pos_next[1:0] == 2'h0) : (pos_next == 3'h0);
    wire       array_mode = (mode_reg == flash_cmd_pkg::OUT_SINGLE) | dual;
    wire       addr_step  = array_mode & (cnt_next > start) & boundary_n;
    wire       is_array   = (byte_now == `OP_READ) | (byte_now == `OP_FAST_READ);
    wire       is_status  = (byte_now == `OP_STATUS1_READ) | (byte_now == `OP_STATUS2_READ);

    always_ff @(posedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= 1'b1;
        end
    end

    always_ff @(posedge link_clk) begin
        ls1_reg  <= sync_src;
        ls2_reg  <= ls1_reg;
        ls3_reg  <= ls2_reg;
        lacc_reg <= (ls2_reg & ls3_reg) | (lacc_reg & (ls2_reg | ls3_reg));
    end

    // the link clock may be stopped in reset, so frame state clears without it
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg   <= 6'h00;
            shin_reg  <= 24'h00_0000;
            op_reg    <= 8'h00;
            byte1_reg <= 8'h00;
            byte2_reg <= 8'h00;
            pos_reg   <= 3'h0;
            addr_reg  <= '0;
            mode_reg  <= flash_cmd_pkg::OUT_NONE;
        end else begin
            cnt_reg  <= cnt_next;
            shin_reg <= {shin_reg[22:0], io0_in};
            pos_reg  <= pos_next;
            if (!active_reg) begin
                mode_reg <= flash_cmd_pkg::OUT_NONE;
            end
            if (cnt_next == `EDGES_OPCODE) begin
                op_reg <= byte_now;
                if (is_status) begin
                    mode_reg <= flash_cmd_pkg::OUT_STATUS;
                end else if (is_array & ~l_busy) begin
                    mode_reg <= flash_cmd_pkg::OUT_SINGLE;
                end else if ((byte_now == `OP_DUAL_READ) & ~l_busy) begin
                    mode_reg <= flash_cmd_pkg::OUT_DUAL;
                end else begin
                    mode_reg <= flash_cmd_pkg::OUT_NONE;
                end
            end
            if (cnt_next == `EDGES_ONE_BYTE) begin
                byte1_reg <= byte_now;
            end
            if (cnt_next == `EDGES_TWO_BYTE) begin
                byte2_reg <= byte_now;
            end
            if (array_mode & (cnt_next == `EDGES_ADDR)) begin
                addr_reg <= ADDR_W'({shin_reg[22:0], io0_in});
            end else if (addr_step) begin
                addr_reg <= addr_reg + ADDR_W'(1);
            end
        end
    end

    assign array_addr = addr_reg;

    // falling-edge output; dummy clocks keep the lines released
    wire       in_data  = (mode_reg != flash_cmd_pkg::OUT_NONE) & (cnt_reg >= start);
    wire       load     = in_data & (dual ? (pos_reg[1:0] == 2'h0) : (pos_reg == 3'h0));
    wire [7:0] src_byte = (mode_reg == flash_cmd_pkg::OUT_STATUS)
                        ? ((op_reg == `OP_STATUS2_READ) ? l_st2 : l_st1)
                        : array_data;
    wire [7:0] cur      = load ? src_byte : shout_reg;

    always_ff @(negedge link_clk or posedge cs_n) begin
        if (cs_n) begin
            io0_out   <= 1'b0;
            io0_oe    <= 1'b0;
            io1_out   <= 1'b0;
            io1_oe    <= 1'b0;
            shout_reg <= 8'h00;
        end else begin
            io1_out   <= cur[7];
            io1_oe    <= in_data;
            io0_out   <= dual & cur[6];
            io0_oe    <= in_data & dual;
            shout_reg <= dual ? {cur[5:0], 2'b00} : {cur[6:0], 1'b0};
        end
    end

    // ---------------- checks ----------------
    a_enable_sets_latch: assert property (@(posedge mclk) disable iff (!nrst)
        op_set_latch |=> status1_reg[`S1_LATCH])
        else $error("write enable did not set latch");

    a_disable_clears: assert property (@(posedge mclk) disable iff (!nrst)
        op_clr_latch |=> !status1_reg[`S1_LATCH])
        else $error("write disable did not clear latch");

    a_vol_keeps_latch: assert property (@(posedge mclk) disable iff (!nrst)
        op_vol |=> status1_reg[`S1_LATCH] == $past(status1_reg[`S1_LATCH]))
        else $error("volatile enable changed latch");

    a_write_starts_busy: assert property (@(posedge mclk) disable iff (!nrst)
        sw_nv |=> status1_reg[`S1_BUSY] && !status1_reg[`S1_LATCH])
        else $error("status write did not start busy cycle");

    a_no_latch_no_write: assert property (@(posedge mclk) disable iff (!nrst)
        (cs_rise && !latch && !vol_en_reg) |=> !$rose(status1_reg[`S1_BUSY]))
        else $error("status write accepted without latch");

    a_bad_length_drop: assert property (@(posedge mclk) disable iff (!nrst)
        (cs_rise && op_reg == `OP_STATUS_WRITE && !len_one && !len_two && !busy)
        |=> $stable(status2_reg) && !status1_reg[`S1_BUSY])
        else $error("status write of wrong length acted");

    a_done_clears: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_done && !op_set_latch) |=> !status1_reg[`S1_BUSY] && !status1_reg[`S1_LATCH])
        else $error("write completion left busy or latch set");

    a_one_byte_clear: assert property (@(posedge mclk) disable iff (!nrst)
        (sw_vol && sw1_ok && len_one) |=> (status2_reg & `S2_WRITE_MASK) == 8'h00)
        else $error("one byte status write kept upper bits");

    a_param_default: assert property (@(posedge mclk)
        !nrst |=> read_param_reg == `PARAM_RESET)
        else $error("read parameter not defaulted");

    a_addr_increment: assert property (@(posedge link_clk) disable iff (!nrst || cs_n)
        addr_step |=> addr_reg == $past(addr_reg) + ADDR_W'(1))
        else $error("read address did not advance");

    a_busy_blocks_read: assert property (@(posedge link_clk) disable iff (!nrst || cs_n)
        (cnt_next == `EDGES_OPCODE && is_array && l_busy)
        |=> mode_reg == flash_cmd_pkg::OUT_NONE)
        else $error("read accepted while busy");

endmodule // flash_cmd_seq

// *** tb/spi_host_model.sv ***
`timescale 1ns/100ps
module spi_host_model (
    // link to device
    output logic       link_clk,
    output logic       cs_n,
    output logic       io0_in,
    // device drive
    input  wire logic  io0_out,
    input  wire logic  io0_oe,
    input  wire logic  io1_out,
    input  wire logic  io1_oe
);
    logic drv;

    // a released line toggles, so a stale value never reads as valid
    assign io0_in = io0_oe ? io0_out : drv;

    initial begin
        link_clk = 1'b0;
        cs_n     = 1'b1;
        drv      = 1'b0;
    end

    // clock stands low outside frames; undriven lines read as x
    task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx,
                        input logic dual, output logic [15:0] rx);
        logic b1;
        logic b0;
        rx   = 16'h0000;
        cs_n = 1'b0;
        #16;
        for (int i = 0; i < ntx; i++) begin
            drv = tx[ntx-1-i];
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
        end
        for (int i = 0; i < nrx; i++) begin
            drv = ~drv;
            #16;
            b1 = io1_oe ? io1_out : 1'bx;
            b0 = io0_oe ? io0_out : 1'bx;
            rx = dual ? {rx[13:0], b1, b0} : {rx[14:0], b1};
            link_clk = 1'b1;
            #16 link_clk = 1'b0;
        end
        #16 cs_n = 1'b1;
        #100;
    endtask
endmodule // spi_host_model

// *** tb/test_flash_cmd_seq.sv ***
`timescale 1ns/100ps
module test_flash_cmd_seq;
    localparam int WRITE_CYCLES = 400;
    logic        mclk, nrst, link_clk, cs_n, io0_in, io0_out, io0_oe, io1_out, io1_oe;
    logic [23:0] array_addr;
    logic [7:0]  array_data, status1_out, status2_out;
    logic [1:0]  read_param_out;
    logic        four_wire_command_mode;
    logic [15:0] rx;
    int          errors = 0, compares = 0, cycles = 0;

    // content mixes two address bytes so a missed increment shows
    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    assign array_data = mem(array_addr);

    flash_cmd_seq #(.ADDR_W(24), .WRITE_CYCLES(WRITE_CYCLES)) flash_cmd_seq_inst (
        .mclk(mclk), .nrst(nrst), .link_clk(link_clk), .cs_n(cs_n), .io0_in(io0_in),
        .io0_out(io0_out), .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe),
        .array_addr(array_addr), .array_data(array_data),
        .four_wire_command_mode(four_wire_command_mode), .status1_out(status1_out),
        .status2_out(status2_out), .read_param_out(read_param_out));

    spi_host_model spi_host_model_inst (
        .link_clk(link_clk), .cs_n(cs_n), .io0_in(io0_in), .io0_out(io0_out),
        .io0_oe(io0_oe), .io1_out(io1_out), .io1_oe(io1_oe));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            finish_test();
        end
    end

    task automatic check_reg(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic check_data(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic send(input logic [39:0] tx, input int ntx);
        spi_host_model_inst.xfer(tx, ntx, 0, 1'b0, rx);
        // realign to mclk so status outputs are never read on their launch edge
        @(negedge mclk);
    endtask

    // bounded poll of busy, then a margin for the crossing
    task automatic wait_idle();
        int n;
        n = 0;
        while (status1_out[0] !== 1'b0 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 1000) begin
            errors++;
            $display("MISMATCH busy expected 0 seen 1");
        end
        repeat (10) @(negedge mclk);
    endtask

    initial begin
        nrst = 1'b0;
        four_wire_command_mode = 1'b0;
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        repeat (5) @(negedge mclk);
        check_reg("status1", 8'h00, status1_out);
        check_reg("status2", 8'h00, status2_out);
        check_reg("read_param", 8'h00, {6'h00, read_param_out});
        send(8'h06, 8);
        check_reg("status1", 8'h02, status1_out);
        spi_host_model_inst.xfer(8'h05, 8, 16, 1'b0, rx);
        check_data("status1_read", 16'h0202, rx);
        send(8'h04, 8);
        check_reg("status1", 8'h00, status1_out);
        send(16'h01FF, 16);
        check_reg("status1", 8'h00, status1_out);
        send(8'h06, 8);
        send(20'h01FFF, 20);
        check_reg("status1", 8'h02, status1_out);
        send({8'h01, 16'hFFFF}, 24);
        check_reg("status1", 8'h01, status1_out);
        spi_host_model_inst.xfer(8'h05, 8, 8, 1'b0, rx);
        check_data("status1_busy", 16'h0001, rx);
        spi_host_model_inst.xfer({8'h03, 24'h000010}, 32, 16, 1'b0, rx);
        check_data("read_busy", 16'hxxxx, rx);
        wait_idle();
        check_reg("status1", 8'hFC, status1_out);
        check_reg("status2", 8'h43, status2_out);
        send(8'h06, 8);
        send(16'h01A4, 16);
        check_reg("status1", 8'hFD, status1_out);
        wait_idle();
        check_reg("status1", 8'hA4, status1_out);
        check_reg("status2", 8'h00, status2_out);
        send(8'h06, 8);
        send(16'h31FF, 16);
        wait_idle();
        check_reg("status2", 8'h43, status2_out);
        check_reg("status1", 8'hA4, status1_out);
        send(8'h50, 8);
        check_reg("status1", 8'hA4, status1_out);
        send(16'h0100, 16);
        check_reg("status1", 8'h00, status1_out);
        check_reg("status2", 8'h00, status2_out);
        spi_host_model_inst.xfer({8'h03, 24'h1234FF}, 32, 16, 1'b0, rx);
        check_data("read", {mem(24'h1234FF), mem(24'h123500)}, rx);
        spi_host_model_inst.xfer({8'h0B, 24'h00ABCD}, 32, 24, 1'b0, rx);
        check_data("fast_read", {mem(24'h00ABCD), mem(24'h00ABCE)}, rx);
        @(negedge mclk);
        four_wire_command_mode = 1'b1;
        // first pass relies on the reset setting of four dummies
        for (int p = 0; p < 3; p++) begin
            if (p > 0) begin
                send({8'hC0, 2'h0, 2'(p), 4'h0}, 16);
            end
            check_reg("read_param", {6'h00, 2'(p)}, {6'h00, read_param_out});
            spi_host_model_inst.xfer({8'h0B, 24'h000040}, 32, 20 + 2 * p, 1'b0, rx);
            check_data("four_wire_read", {mem(24'h40), mem(24'h41)}, rx);
        end
        @(negedge mclk);
        four_wire_command_mode = 1'b0;
        spi_host_model_inst.xfer({8'h3B, 24'h0001FF}, 32, 16, 1'b1, rx);
        check_data("dual_read", {mem(24'h0001FF), mem(24'h000200)}, rx);
        finish_test();
    end
endmodule // test_flash_cmd_seq
